// [pegq_ctrl.sv]
// module: per-port egress queue scheduler, shaper configuration, schedule and drop control
//
// Strobed register access was decided locally.
`default_nettype none
module pegq_ctrl
  import pegq_pkg::*;
#(
  parameter int NUM_QUEUES = 4,
  parameter int NUM_EVENTS = 128,
  parameter int NUM_PORTS = 7,
  parameter int SECOND_COUNT = SECOND_CYCLES
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pegq_bus_type bus,
  output logic [31:0] rdata,
  input wire logic single_queue,
  input wire logic [NUM_QUEUES-1:0] queue_pending,
  input wire logic packet_sent,
  input wire logic pps_pin,
  input wire logic ref_time_crossed,
  input wire logic dest_congested,
  input wire logic [1:0] pkt_priority,
  input wire logic [NUM_PORTS-1:0] fwd_request,
  output logic [1:0] serve_queue,
  output logic gate_open,
  output logic guard_band,
  output logic tas_may_send,
  output logic tas_cut_through,
  output logic flow_control,
  output logic drop_packet,
  output logic [NUM_PORTS-1:0] fwd_allowed,
  output pegq_queue_type serve_cfg
);
  ////////////////////////////////////////////////////////////////////////////
  // the register map and priority encoder are sized for exactly these counts
  if (NUM_QUEUES != 4 || NUM_EVENTS != 128 || NUM_PORTS != 7
      || SECOND_COUNT < 2) begin : g_bad_param
    $error("pegq_ctrl: unsupported parameter value");
  end

  typedef enum logic [2:0] {
    SCH_IDLE = 3'h1,
    SCH_RUN = 3'h2,
    SCH_WAIT = 3'h4
  } pegq_sched_state_type;

  logic [1:0] queue_index_reg;
  pegq_queue_type queue_cfg_reg [NUM_QUEUES];
  logic [7:0] tas_ctrl_reg;
  logic [6:0] event_index_reg;
  pegq_event_type event_mem [NUM_EVENTS];
  logic [1:0] drop_mode_reg;
  logic [6:0] membership_reg;
  logic pps_meta_reg, pps_sync_reg, pps_prev_reg;
  logic ref_meta_reg, ref_sync_reg, ref_prev_reg;
  logic [31:0] second_count_reg;
  logic [28:0] cycle_reg;
  logic [6:0] step_reg;
  pegq_sched_state_type state_reg;
  logic [6:0] sent_count_reg;
  logic [1:0] serve_reg;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
    hit = (a == base);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      queue_index_reg <= 2'h0;
      tas_ctrl_reg <= 8'h00;
      event_index_reg <= 7'h00;
      drop_mode_reg <= 2'h0;
      membership_reg <= RST_MEMBERSHIP;
    end else if (bus.wr) begin
      if (hit(bus.addr, ADDR_QUEUE_INDEX)) queue_index_reg <= bus.wdata[1:0];
      if (hit(bus.addr, ADDR_TAS_CTRL)) tas_ctrl_reg <= {bus.wdata[7:6], 4'h0, bus.wdata[1:0]};
      if (hit(bus.addr, ADDR_EVENT_INDEX)) event_index_reg <= bus.wdata[6:0];
      if (hit(bus.addr, ADDR_DROP_MODE)) drop_mode_reg <= bus.wdata[1:0];
      if (hit(bus.addr, ADDR_MEMBERSHIP)) membership_reg <= bus.wdata[6:0];
    end
  end

  generate
    for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_queue
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          queue_cfg_reg[q].sched_mode <= RST_SCHED_MODE;
          queue_cfg_reg[q].shaper_mode <= SHAPER_NONE;
          queue_cfg_reg[q].weight <= RST_WEIGHT;
          queue_cfg_reg[q].credit_high <= RST_CREDIT_HIGH;
          queue_cfg_reg[q].credit_low <= RST_CREDIT_LOW;
          queue_cfg_reg[q].credit_incr <= RST_CREDIT_INCR;
        end else if (bus.wr && queue_index_reg == 2'(q)) begin
          if (hit(bus.addr, ADDR_QUEUE_CTRL)) begin
            queue_cfg_reg[q].sched_mode <= bus.wdata[SCHED_LSB+:2];
            queue_cfg_reg[q].shaper_mode <= bus.wdata[SHAPER_LSB+:2];
          end
          if (hit(bus.addr, ADDR_WRR_WEIGHT)) queue_cfg_reg[q].weight <= bus.wdata[6:0];
          if (hit(bus.addr, ADDR_CREDIT_HIGH)) queue_cfg_reg[q].credit_high <= bus.wdata[15:0];
          if (hit(bus.addr, ADDR_CREDIT_LOW)) queue_cfg_reg[q].credit_low <= bus.wdata[15:0];
          if (hit(bus.addr, ADDR_CREDIT_INCR)) queue_cfg_reg[q].credit_incr <= bus.wdata[15:0];
        end
      end
    end
  endgenerate

  // schedule memory has no reset; it is written by software before use
  always_ff @(posedge clk_sys) begin
    if (bus.wr && hit(bus.addr, ADDR_EVENT_ENTRY)) begin
      event_mem[event_index_reg] <= bus.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data in the cycle after the strobe only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0000_0000;
    end else if (!bus.rd) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= 32'h0000_0000;
      if (hit(bus.addr, ADDR_QUEUE_INDEX)) rdata <= {30'h0, queue_index_reg};
      if (hit(bus.addr, ADDR_QUEUE_CTRL)) begin
        rdata <= {24'h0, queue_cfg_reg[queue_index_reg].sched_mode,
                  queue_cfg_reg[queue_index_reg].shaper_mode, 4'h0};
      end
      if (hit(bus.addr, ADDR_WRR_WEIGHT)) rdata <= {25'h0, queue_cfg_reg[queue_index_reg].weight};
      if (hit(bus.addr, ADDR_CREDIT_HIGH)) begin
        rdata <= {16'h0, queue_cfg_reg[queue_index_reg].credit_high};
      end
      if (hit(bus.addr, ADDR_CREDIT_LOW)) rdata <= {16'h0, queue_cfg_reg[queue_index_reg].credit_low};
      if (hit(bus.addr, ADDR_CREDIT_INCR)) begin
        rdata <= {16'h0, queue_cfg_reg[queue_index_reg].credit_incr};
      end
      if (hit(bus.addr, ADDR_TAS_CTRL)) rdata <= {24'h0, tas_ctrl_reg};
      if (hit(bus.addr, ADDR_EVENT_INDEX)) rdata <= {25'h0, event_index_reg};
      if (hit(bus.addr, ADDR_EVENT_ENTRY)) rdata <= event_mem[event_index_reg];
      if (hit(bus.addr, ADDR_DROP_MODE)) rdata <= {30'h0, drop_mode_reg};
      if (hit(bus.addr, ADDR_MEMBERSHIP)) rdata <= {25'h0, membership_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pps_meta_reg <= 1'b0;
      pps_sync_reg <= 1'b0;
      pps_prev_reg <= 1'b0;
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      pps_meta_reg <= pps_pin;
      pps_sync_reg <= pps_meta_reg;
      pps_prev_reg <= pps_sync_reg;
      ref_meta_reg <= ref_time_crossed;
      ref_sync_reg <= ref_meta_reg;
      ref_prev_reg <= ref_sync_reg;
    end
  end

  // internal one-second tick
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      second_count_reg <= 32'h0000_0000;
    end else if (second_count_reg == 32'(SECOND_COUNT - 1)) begin
      second_count_reg <= 32'h0000_0000;
    end else begin
      second_count_reg <= second_count_reg + 32'h0000_0001;
    end
  end

  logic pps_edge, cross_edge, second_tick, cycle_start, tas_active;
  pegq_event_type cur_event;
  assign pps_edge = pps_sync_reg && !pps_prev_reg;
  assign cross_edge = ref_sync_reg && !ref_prev_reg;
  assign second_tick = (second_count_reg == 32'(SECOND_COUNT - 1));
  assign cur_event = event_mem[step_reg];

  always_comb begin
    case (tas_ctrl_reg[1:0])
      REF_CROSS: cycle_start = cross_edge;
      REF_PPS: cycle_start = pps_edge;
      REF_SECOND: cycle_start = second_tick;
      default: cycle_start = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate schedule walker
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tas_active <= 1'b0;
      cycle_reg <= 29'h0;
      step_reg <= 7'h00;
      gate_open <= 1'b0;
      guard_band <= 1'b0;
    end else if (cycle_start) begin
      tas_active <= 1'b1;
      cycle_reg <= 29'h0;
      step_reg <= 7'h00;
    end else if (tas_ctrl_reg[1:0] == REF_NONE) begin
      tas_active <= 1'b0;
      gate_open <= 1'b0;
      guard_band <= 1'b0;
    end else if (tas_active) begin
      cycle_reg <= cycle_reg + 29'h1;
      if (cycle_reg >= cur_event.time_cycles) begin
        step_reg <= step_reg + 7'h01;
        case (cur_event.code)
          EV_REPEAT: begin
            step_reg <= 7'h00;
            cycle_reg <= 29'h0;
          end
          EV_OPEN: begin
            gate_open <= 1'b1;
            guard_band <= 1'b0;
          end
          EV_GUARD: guard_band <= 1'b1;
          EV_CLOSE: begin
            gate_open <= 1'b0;
            guard_band <= 1'b0;
          end
          default: guard_band <= guard_band;
        endcase
      end
    end
  end

  // restricted mode holds packets until open; cut-through forwarded
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tas_may_send <= 1'b1;
      tas_cut_through <= 1'b0;
    end else begin
      tas_may_send <= !tas_ctrl_reg[RESTRICTED_BIT] || (gate_open && !guard_band);
      tas_cut_through <= tas_ctrl_reg[CUT_THROUGH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // queue scheduler; queue 0 mode word decides the port policy
  function automatic logic [1:0] highest(input logic [3:0] p);
    highest = p[3] ? 2'h3 : p[2] ? 2'h2 : p[1] ? 2'h1 : 2'h0;
  endfunction

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SCH_IDLE;
      serve_reg <= 2'h0;
      sent_count_reg <= 7'h00;
    end else begin
      case (state_reg)
        SCH_IDLE: begin
          sent_count_reg <= 7'h00;
          if (single_queue) begin
            serve_reg <= 2'h0;
          end else if (queue_cfg_reg[0].sched_mode != SCHED_WRR) begin
            serve_reg <= highest(queue_pending);
          end else if (|queue_pending) begin
            state_reg <= SCH_RUN;
          end
        end
        SCH_RUN: begin
          if (single_queue || queue_cfg_reg[0].sched_mode != SCHED_WRR) begin
            state_reg <= SCH_IDLE;
          end else if (!queue_pending[serve_reg]) begin
            state_reg <= SCH_WAIT;
          end else if (packet_sent) begin
            // weight zero is not legal, so a count of one is the least
            if (sent_count_reg + 7'h01 >= queue_cfg_reg[serve_reg].weight) begin
              state_reg <= SCH_WAIT;
            end else begin
              sent_count_reg <= sent_count_reg + 7'h01;
            end
          end
        end
        SCH_WAIT: begin
          serve_reg <= serve_reg + 2'h1;
          sent_count_reg <= 7'h00;
          state_reg <= SCH_RUN;
        end
        default: state_reg <= SCH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      serve_queue <= 2'h0;
      serve_cfg <= '0;
    end else begin
      serve_queue <= serve_reg;
      serve_cfg <= queue_cfg_reg[serve_reg];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // congestion handling and port membership
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flow_control <= 1'b0;
      drop_packet <= 1'b0;
    end else begin
      flow_control <= dest_congested && drop_mode_reg == 2'h0;
      drop_packet <= dest_congested && drop_mode_reg != 2'h0 && pkt_priority < drop_mode_reg;
    end
  end

  // no tag or table input exists here, so filtering cannot depend on them
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fwd_allowed <= '0;
    end else begin
      fwd_allowed <= fwd_request & membership_reg;
    end
  end
endmodule
`default_nettype wire

// [pegq_ctrl_asserts.sv]
// checker: port-level properties of the egress queue control
`default_nettype none
module pegq_ctrl_checker
  import pegq_pkg::*;
#(
  parameter int NUM_QUEUES = 4,
  parameter int NUM_PORTS = 7
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pegq_bus_type bus,
  input wire logic [31:0] rdata,
  input wire logic single_queue,
  input wire logic [NUM_QUEUES-1:0] queue_pending,
  input wire logic packet_sent,
  input wire logic dest_congested,
  input wire logic [1:0] pkt_priority,
  input wire logic [NUM_PORTS-1:0] fwd_request,
  input wire logic [1:0] serve_queue,
  input wire logic gate_open,
  input wire logic guard_band,
  input wire logic tas_may_send,
  input wire logic tas_cut_through,
  input wire logic flow_control,
  input wire logic drop_packet,
  input wire logic [NUM_PORTS-1:0] fwd_allowed,
  input wire pegq_queue_type serve_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic live;
  logic quiet;
  logic [1:0] s0;
  logic [1:0] qidx;
  logic [1:0] last_q;
  logic [6:0] wt [NUM_QUEUES];
  logic [6:0] exp_w;
  logic [NUM_PORTS-1:0] memb;
  logic [1:0] drop;
  logic [7:0] tas;
  logic [7:0] run;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the writes; queue 0 mode word picks strict or round robin for the port
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      qidx <= 2'h0;
      memb <= NUM_PORTS'(RST_MEMBERSHIP);
      drop <= 2'h0;
      tas <= 8'h00;
      s0 <= RST_SCHED_MODE;
      for (int i = 0; i < NUM_QUEUES; i++)
        wt[i] <= RST_WEIGHT;
    end else if (bus.wr) begin
      case (bus.addr)
        ADDR_QUEUE_INDEX: qidx <= bus.wdata[1:0];
        ADDR_WRR_WEIGHT: wt[qidx] <= bus.wdata[6:0];
        ADDR_MEMBERSHIP: memb <= bus.wdata[NUM_PORTS-1:0];
        ADDR_DROP_MODE: drop <= bus.wdata[1:0];
        ADDR_TAS_CTRL: tas <= bus.wdata[7:0];
        ADDR_QUEUE_CTRL: if (qidx == 2'h0) s0 <= bus.wdata[SCHED_LSB+:2];
        default: ;
      endcase
    end
  end
  // run counts packets finished since the served queue last changed; it restarts
  // a cycle late after single-queue or strict spells, as the scheduler re-enters then
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      live <= 1'b0;
      quiet <= 1'b0;
      exp_w <= 7'h00;
      last_q <= 2'h0;
      run <= 8'h00;
    end else begin
      live <= 1'b1;
      quiet <= single_queue || s0 != SCHED_WRR;
      exp_w <= wt[qidx];
      last_q <= serve_queue;
      if (single_queue || quiet || s0 != SCHED_WRR)
        run <= 8'h00;
      else if (serve_queue != last_q)
        run <= {7'h00, packet_sent};
      else
        run <= run + {7'h00, packet_sent};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_weight_readback: assert property (bus.rd && bus.addr == ADDR_WRR_WEIGHT
    |=> rdata == {25'h0, exp_w}) else $error("queue weight read mismatch");
  a_member_readback: assert property (bus.rd && bus.addr == ADDR_MEMBERSHIP
    |=> rdata == 32'(memb)) else $error("membership read mismatch");
  a_member_filter: assert property (live |->
    fwd_allowed == ($past(fwd_request) & $past(memb))) else $error("forward mask wrong");
  a_flow_ctrl_mode: assert property (live |->
    flow_control == ($past(dest_congested) && $past(drop) == 2'h0))
    else $error("flow control wrong");
  a_drop_by_prio: assert property (live |->
    drop_packet == ($past(dest_congested) && $past(pkt_priority) < $past(drop)))
    else $error("drop decision wrong");
  a_cut_through_bit: assert property (live && $stable(tas)
    |-> tas_cut_through == tas[CUT_THROUGH_BIT]) else $error("cut-through wrong");
  a_unrestricted_send: assert property (live && $stable(tas) && !tas[RESTRICTED_BIT]
    |-> tas_may_send) else $error("unrestricted traffic held");
  // the guard band also holds restricted traffic, so a frame never overruns the close
  a_restricted_gate: assert property (live && tas[RESTRICTED_BIT] && $stable(tas)
    && $stable(gate_open) && $stable(guard_band)
    |-> tas_may_send == (gate_open && !guard_band)) else $error("restricted gating wrong");
  // the scheduler may need a wait, a run and an idle step before it settles on zero
  a_single_queue_zero: assert property (single_queue [*5]
    |-> serve_queue == 2'h0) else $error("single queue not served from zero");
  a_strict_highest: assert property ((s0 == SCHED_STRICT && !single_queue
    && queue_pending[3]) [*5] |-> serve_queue == 2'h3) else $error("strict mode not highest");
  a_serve_cfg_weight: assert property (live && !$past(bus.wr)
    |-> serve_cfg.weight == wt[serve_queue]) else $error("served queue config wrong");
  a_wrr_run_limit: assert property (live && !single_queue && serve_queue == last_q
    |-> run <= 8'(wt[serve_queue])) else $error("queue overran its weight");
  c_drop: cover property (drop_packet);
  c_flow: cover property (flow_control);
  c_gate: cover property (gate_open && tas_may_send && tas_cut_through);
endmodule
`default_nettype wire

// [pegq_ctrl_tb.sv]
// testbench: registers, schedule walk, drop and membership of the egress queue control
`default_nettype none
module pegq_ctrl_tb
  import pegq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  pegq_bus_type bus = '0;
  logic single_queue = 1'b0;
  logic pps_pin = 1'b0;
  logic ref_time_crossed = 1'b0;
  logic dest_congested = 1'b0;
  logic [1:0] pkt_priority = 2'h0;
  logic [6:0] fwd_request = 7'h00;
  logic [31:0] seed = 32'h9277;
  logic rd_pend = 1'b0;
  logic [31:0] rdata;
  logic [3:0] queue_pending;
  logic packet_sent, gate_open, guard_band, tas_may_send, tas_cut_through;
  logic flow_control, drop_packet;
  logic [1:0] serve_queue;
  logic [6:0] fwd_allowed;
  pegq_queue_type serve_cfg;
  logic [31:0] expq [$];
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] ev [5] = '{{EV_OPEN, 29'h2}, {EV_GUARD, 29'h6}, {EV_CLOSE, 29'h9},
    {EV_REPEAT, 29'hC}, {EV_CLOSE, 29'h1FFFFFFF}};
  int ei [5] = '{0, 1, 2, 3, 127};
  // a short second keeps the free-running reference inside the run
  pegq_ctrl #(.SECOND_COUNT(20)) uut (.clk_sys, .arst_n, .bus, .rdata, .single_queue,
    .queue_pending, .packet_sent, .pps_pin, .ref_time_crossed, .dest_congested,
    .pkt_priority, .fwd_request, .serve_queue, .gate_open, .guard_band, .tas_may_send,
    .tas_cut_through, .flow_control, .drop_packet, .fwd_allowed, .serve_cfg);
  pegq_fabric_model fab (.clk_sys, .arst_n, .rnd(seed), .queue_pending, .packet_sent);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one bus cycle per call: write when w is set, otherwise a read expecting e
  task automatic acc(input logic [11:0] a, input logic [31:0] d, input logic w,
    input logic [31:0] e);
    bus <= '{a, d, w, !w};
    if (!w)
      expq.push_back(e);
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wait_gate(input logic v);
    int k = 0;
    idle(1);
    while (gate_open !== v && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    cmp({31'h0, gate_open}, {31'h0, v});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    seed <= xs(seed);
    pkt_priority <= seed[1:0];
    dest_congested <= seed[2];
    fwd_request <= seed[9:3];
    cyc++;
    if (rd_pend)
      cmp(rdata, expq.pop_front());
    rd_pend <= bus.rd;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    logic [6:0] m;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (int q = 0; q < 4; q++) begin
      acc(ADDR_QUEUE_INDEX, q, 1'b1, 0);
      acc(ADDR_WRR_WEIGHT, 0, 1'b0, 32'h01);
      acc(ADDR_CREDIT_HIGH, 0, 1'b0, 32'h0534);
      acc(ADDR_CREDIT_LOW, 0, 1'b0, 32'h05F2);
      acc(ADDR_CREDIT_INCR, 0, 1'b0, 32'h2000);
    end
    acc(ADDR_MEMBERSHIP, 0, 1'b0, 32'h7F);
    acc(ADDR_DROP_MODE, 0, 1'b0, 32'h0);
    acc(ADDR_EVENT_INDEX, 0, 1'b0, 32'h0);
    acc(12'h904, 0, 1'b0, 32'h0);
    acc(ADDR_QUEUE_INDEX, 32'hFF, 1'b1, 0);
    acc(ADDR_QUEUE_INDEX, 0, 1'b0, 32'h3);
    // index written first every time, weights never zero, bit 7 must not stick
    for (int q = 0; q < 4; q++) begin
      acc(ADDR_QUEUE_INDEX, q, 1'b1, 0);
      acc(ADDR_WRR_WEIGHT, 32'h81 + q, 1'b1, 0);
      acc(ADDR_QUEUE_CTRL, 32'h8F + 16 * (q % 3), 1'b1, 0);
      acc(ADDR_CREDIT_HIGH, 32'hFFFF1000 + q, 1'b1, 0);
      acc(ADDR_CREDIT_LOW, 32'h2000 + q, 1'b1, 0);
      acc(ADDR_CREDIT_INCR, 32'h3000 + q, 1'b1, 0);
    end
    for (int q = 0; q < 4; q++) begin
      acc(ADDR_QUEUE_INDEX, q, 1'b1, 0);
      acc(ADDR_WRR_WEIGHT, 0, 1'b0, 32'h1 + q);
      acc(ADDR_QUEUE_CTRL, 0, 1'b0, 32'h80 + 16 * (q % 3));
      acc(ADDR_CREDIT_HIGH, 0, 1'b0, 32'h1000 + q);
      acc(ADDR_CREDIT_LOW, 0, 1'b0, 32'h2000 + q);
      acc(ADDR_CREDIT_INCR, 0, 1'b0, 32'h3000 + q);
    end
    repeat (4) begin
      m = seed[16:10];
      acc(ADDR_MEMBERSHIP, {25'h0, m}, 1'b1, 0);
      acc(ADDR_MEMBERSHIP, 0, 1'b0, {25'h0, m});
      idle(10);
    end
    for (int d = 0; d < 4; d++) begin
      acc(ADDR_DROP_MODE, d, 1'b1, 0);
      acc(ADDR_DROP_MODE, 0, 1'b0, d);
      idle(16);
    end
    single_queue <= 1'b1;
    idle(10);
    single_queue <= 1'b0;
    // a strict priority spell, then back to round robin through queue 0's mode word
    acc(ADDR_QUEUE_INDEX, 0, 1'b1, 0);
    acc(ADDR_QUEUE_CTRL, 32'h0F, 1'b1, 0);
    acc(ADDR_QUEUE_CTRL, 0, 1'b0, 32'h0);
    idle(12);
    acc(ADDR_QUEUE_CTRL, 32'h80, 1'b1, 0);
    for (int i = 0; i < 5; i++) begin
      acc(ADDR_EVENT_INDEX, ei[i], 1'b1, 0);
      acc(ADDR_EVENT_ENTRY, ev[i], 1'b1, 0);
    end
    acc(ADDR_EVENT_INDEX, 0, 1'b0, 32'h7F);
    for (int i = 0; i < 5; i++) begin
      acc(ADDR_EVENT_INDEX, ei[i], 1'b1, 0);
      acc(ADDR_EVENT_ENTRY, 0, 1'b0, ev[i]);
    end
    // each start reference in turn, from a stopped schedule
    for (int r = 3; r > 0; r--) begin
      acc(ADDR_TAS_CTRL, 0, 1'b1, 0);
      wait_gate(1'b0);
      acc(ADDR_TAS_CTRL, 32'hC0 + r, 1'b1, 0);
      pps_pin <= 1'b1;
      ref_time_crossed <= 1'b1;
      idle(4);
      pps_pin <= 1'b0;
      ref_time_crossed <= 1'b0;
      wait_gate(1'b1);
      wait_gate(1'b0);
    end
    acc(ADDR_TAS_CTRL, 32'h01, 1'b1, 0);
    idle(30);
    acc(ADDR_TAS_CTRL, 0, 1'b1, 0);
    idle(30);
    cmp({31'h0, gate_open}, 32'h0);
    summarize();
  end
endmodule
bind pegq_ctrl pegq_ctrl_checker #(.NUM_QUEUES(NUM_QUEUES), .NUM_PORTS(NUM_PORTS)) chk (
  .clk_sys, .arst_n, .bus, .rdata, .single_queue, .queue_pending, .packet_sent,
  .dest_congested, .pkt_priority, .fwd_request, .serve_queue, .gate_open, .guard_band,
  .tas_may_send, .tas_cut_through, .flow_control, .drop_packet, .fwd_allowed, .serve_cfg);
`default_nettype wire

// [pegq_fabric_model.sv]
// partner model: forwarding fabric and transmit mac facing the egress queue control
`default_nettype none
module pegq_fabric_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [31:0] rnd,
  output logic [3:0] queue_pending,
  output logic packet_sent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] len_reg;
  // every queue stays backlogged so the scheduler always has a choice to make
  assign queue_pending = 4'hF;
  ////////////////////////////////////////////////////////////////////////////////
  // packets take two, four, six or eight cycles, so completions come both quick and slow
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      len_reg <= 3'h0;
      packet_sent <= 1'b0;
    end else begin
      packet_sent <= (len_reg == 3'h1);
      if (len_reg == 3'h0)
        len_reg <= {rnd[4:3], 1'b1};
      else
        len_reg <= len_reg - 3'h1;
    end
  end
endmodule
`default_nettype wire

// [pegq_pkg.sv]
// package: register map, field layout, reset values and codes of the egress queue shaper control
// Notes on behaviour
// - queue-indexed registers act on the queue chosen by a 2-bit queue index register
// - weighted round robin mode (10) serves every queue in turn, a limited count each
// - per-queue shaper mode: 00 none, 01 credit based, 10 time aware, 11 reserved
// - 7-bit queue weight sets packets sent before moving to the next queue
// - queue weights are ignored when the port runs a single egress queue
// - every queue weight resets to one
// - per-queue 16-bit credit high water mark in bytes, reset 0x0534
// - per-queue 16-bit credit low water mark in bytes, reset 0x05F2
// - per-queue 16-bit credit increment, reset 0x2000 meaning 12.5 percent
// - time shaper control bit 7 enables cut-through of time-aware traffic
// - restricted bit 6 holds time-aware packets until the open period
// - reference select: 11 once at reference, 10 each pps, 01 internal second, 00 none
// - event code: 111 repeat, 010 open, 001 guard band, 000 close, others reserved
// - each event holds a 29-bit time in system clock cycles
// - drop mode 00: no drops, flow control to the port during congestion
// - drop modes 01/10/11 drop priorities up to 0/1/2 and stop flow control
// - 7-bit port membership mask, bit 0 is port 1, resets to 0x7F
// - set membership bit allows forwarding to that port, clear bit blocks it
// - membership filtering ignores VLAN tags and the VLAN table
`default_nettype none
package pegq_pkg;
  localparam logic [11:0] ADDR_QUEUE_INDEX = 12'h900;
  localparam logic [11:0] ADDR_QUEUE_CTRL = 12'h914;
  localparam logic [11:0] ADDR_WRR_WEIGHT = 12'h915;
  localparam logic [11:0] ADDR_CREDIT_HIGH = 12'h916;
  localparam logic [11:0] ADDR_CREDIT_LOW = 12'h918;
  localparam logic [11:0] ADDR_CREDIT_INCR = 12'h91A;
  localparam logic [11:0] ADDR_TAS_CTRL = 12'h920;
  localparam logic [11:0] ADDR_EVENT_INDEX = 12'h923;
  localparam logic [11:0] ADDR_EVENT_ENTRY = 12'h924;
  localparam logic [11:0] ADDR_DROP_MODE = 12'hA00;
  localparam logic [11:0] ADDR_MEMBERSHIP = 12'hA04;
  localparam logic [6:0] RST_WEIGHT = 7'h01;
  localparam logic [15:0] RST_CREDIT_HIGH = 16'h0534;
  localparam logic [15:0] RST_CREDIT_LOW = 16'h05F2;
  localparam logic [15:0] RST_CREDIT_INCR = 16'h2000;
  localparam logic [1:0] RST_SCHED_MODE = 2'h2;
  localparam logic [6:0] RST_MEMBERSHIP = 7'h7F;
  localparam int SCHED_LSB = 6;
  localparam int SHAPER_LSB = 4;
  localparam int CUT_THROUGH_BIT = 7;
  localparam int RESTRICTED_BIT = 6;
  localparam int EVENT_CODE_LSB = 29;
  localparam logic [1:0] SCHED_STRICT = 2'h0;
  localparam logic [1:0] SCHED_WRR = 2'h2;
  localparam logic [1:0] SHAPER_NONE = 2'h0;
  localparam logic [1:0] SHAPER_CBS = 2'h1;
  localparam logic [1:0] SHAPER_TAS = 2'h2;
  localparam logic [1:0] REF_NONE = 2'h0;
  localparam logic [1:0] REF_SECOND = 2'h1;
  localparam logic [1:0] REF_PPS = 2'h2;
  localparam logic [1:0] REF_CROSS = 2'h3;
  localparam logic [2:0] EV_CLOSE = 3'h0;
  localparam logic [2:0] EV_GUARD = 3'h1;
  localparam logic [2:0] EV_OPEN = 3'h2;
  localparam logic [2:0] EV_REPEAT = 3'h7;
  localparam int CLK_MHZ = 250;
  localparam int SECOND_NS = 1000000000;
  localparam int SECOND_CYCLES = SECOND_NS / 1000 * CLK_MHZ;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pegq_bus_type;
  typedef struct packed {
    logic [1:0] sched_mode;
    logic [1:0] shaper_mode;
    logic [6:0] weight;
    logic [15:0] credit_high;
    logic [15:0] credit_low;
    logic [15:0] credit_incr;
  } pegq_queue_type;
  typedef struct packed {
    logic [2:0] code;
    logic [28:0] time_cycles;
  } pegq_event_type;
endpackage
`default_nettype wire
